// >>> common/rcseq_pkg.sv
// rcseq_pkg: constants and types for the relay channel sequencer
// assumes a 25 MHz system clock
package rcseq_pkg;
  localparam int SLOTS          = 12;
  localparam int SLOT_W         = 4;
  localparam int CH_W           = 5;
  localparam int CHID_W         = 11;
  localparam int SLOT_SCALE     = 100;
  localparam int CH22_COUNT     = 22;
  localparam int CH6_COUNT      = 6;
  localparam int CH4W_COUNT     = 11;
  localparam int SENSE_OFFSET   = 11;
  localparam int CLK_MHZ        = 25;
  localparam int RELAY_US       = 5;
  localparam int RELAY_CYC      = RELAY_US * CLK_MHZ;
  localparam int SETTLE_US      = 10;
  localparam int SETTLE_CYC     = SETTLE_US * CLK_MHZ;
  localparam int CNT_W          = 32;
  localparam logic SLOT_TYPE_22 = 1'b0;
  localparam logic SLOT_TYPE_6  = 1'b1;

  typedef enum logic [1:0] {
    two_wire_method,
    four_wire_method,
    four_terminal_pair_method
  } rcseq_method_type;

  typedef enum logic [2:0] {
    SHLD_OFF,
    SHLD_GND,
    SHLD_T1_LOW,
    SHLD_T23_SRC_LOW,
    SHLD_T3_SENSE,
    SHLD_DUAL
  } rcseq_shield_type;
endpackage : rcseq_pkg

// >>> src/rcseq_top.sv
// rcseq_top: slot settings, close/open decode, relay sequencing
// assumes host strobes are synchronous one-cycle pulses on CLOCK
//
// Function
// - per slot, accept a shield destination from the module type's fixed set
// - shield setting persists until that slot's method changes
// - writing a shield destination opens every channel relay
// - channel id is slot times 100 plus channel; device decodes both
// - close drives addressed channel relay plus that slot's bus relay
// - open-all request opens every channel relay
// - at most one channel closed; new close replaces old
// - close request itself starts the switching sequence
// - completion query answered with 1 only after switching finishes
// - later commands held off while completion query is pending
// - new close ends an unfinished completion pulse at once
// - open previous channel before closing new one, no overlap
// - same slot keeps bus relay closed, switches only channel relays
// - other slot: open old bus and channel, then close new ones
// - after close, wait settle plus user delay, then done and pulse
// - relay switching time counts inside the channel delay
// - method change restores slot shield to that method's default
// - defaults: two-wire T1 low, four-wire ground, pair T3 sense shield
// - setting a connection method opens all channel relays
// - four-wire 22-channel: source n pairs with sense n plus 11
`timescale 1ns/10ps
`default_nettype none
module rcseq_top
  import rcseq_pkg::*;
(
  input  wire logic                 CLOCK,
  input  wire logic                 RESET,
  input  wire logic [SLOTS-1:0]     SLOT_TYPE,
  input  wire logic                 METHOD_WRITE,
  input  wire logic                 SHIELD_WRITE,
  input  wire logic [SLOT_W-1:0]    SET_SLOT,
  input  wire logic [1:0]           SET_METHOD,
  input  wire logic [2:0]           SET_SHIELD,
  input  wire logic                 CLOSE_REQUEST,
  input  wire logic [CHID_W-1:0]    CLOSE_CHANNEL_ID,
  input  wire logic                 OPEN_ALL_REQUEST,
  input  wire logic                 COMPLETE_QUERY,
  input  wire logic [CNT_W-1:0]     CHANNEL_DELAY,
  input  wire logic [CNT_W-1:0]     PULSE_WIDTH,
  output logic                      COMMAND_READY,
  output logic                      QUERY_REPLY_VALID,
  output logic [7:0]                QUERY_REPLY,
  output logic                      CLOSE_REJECT,
  output logic [SLOTS-1:0]          BUS_RELAY,
  output logic [SLOT_W-1:0]         RELAY_SLOT,
  output logic [CH_W-1:0]           CHANNEL_RELAY,
  output logic [CH_W-1:0]           SENSE_RELAY,
  output logic                      CHANNEL_CLOSED,
  output logic [3*SLOTS-1:0]        SHIELD_SELECT,
  output logic [2*SLOTS-1:0]        METHOD_SELECT,
  output logic                      SWITCH_BUSY,
  output logic                      external_control_port
);

  typedef enum logic [2:0] {
    S_IDLE, S_BREAK, S_MAKE, S_WAIT, S_DONE
  } rcseq_state_type;

  rcseq_method_type method [SLOTS];
  rcseq_method_type next_method [SLOTS];
  rcseq_shield_type shield [SLOTS];
  rcseq_shield_type next_shield [SLOTS];

  rcseq_state_type  state, next_state;
  logic [SLOT_W-1:0] cur_slot, next_cur_slot, tgt_slot, next_tgt_slot;
  logic [CH_W-1:0]   cur_ch, next_cur_ch, tgt_ch, next_tgt_ch;
  logic              closed, next_closed;
  logic [SLOTS-1:0]  bus, next_bus;
  logic [CNT_W-1:0]  wait_cnt, next_wait_cnt, width, next_width;
  logic [CNT_W-1:0]  pulse_cnt, next_pulse_cnt;
  logic              pulse, next_pulse;
  logic              query_pend, next_query_pend;
  logic              reply_v, next_reply_v, reject, next_reject;

  // default shield for a connection method
  function automatic rcseq_shield_type default_shield(
    input rcseq_method_type m);
    if (m == four_wire_method) begin
      default_shield = SHLD_GND;
    end else if (m == four_terminal_pair_method) begin
      default_shield = SHLD_T3_SENSE;
    end else begin
      default_shield = SHLD_T1_LOW;
    end
  endfunction

  // shield allowed on module type
  function automatic logic shield_ok(input logic typ,
                                     input logic [2:0] s);
    if (typ == SLOT_TYPE_22) begin
      shield_ok = (s <= 3'(SHLD_DUAL));
    end else begin
      shield_ok = (s <= 3'(SHLD_T1_LOW)) || (s == 3'(SHLD_T3_SENSE));
    end
  endfunction

  // slot number inside the fitted range
  function automatic logic slot_valid(input logic [CHID_W-1:0] n);
    slot_valid = (n >= CHID_W'(1)) && (n <= CHID_W'(SLOTS));
  endfunction

  // connection method fitted to module type
  function automatic logic method_ok(input logic typ,
                                     input logic [1:0] m);
    if (typ == SLOT_TYPE_22) begin
      method_ok = (m == 2'(two_wire_method)) || (m == 2'(four_wire_method));
    end else begin
      method_ok = (m == 2'(two_wire_method))
                  || (m == 2'(four_terminal_pair_method));
    end
  endfunction

  // decoded request
  logic [SLOT_W-1:0] req_slot;
  logic [CH_W-1:0]   req_ch;
  logic [CHID_W-1:0] slot_full;
  logic [CHID_W-1:0] ch_full;
  logic              slot_in;
  logic              req_ok;
  logic [6:0]        max_ch;
  logic              cfg_write;

  always_comb begin
    slot_full = CLOSE_CHANNEL_ID / CHID_W'(SLOT_SCALE);
    ch_full   = CLOSE_CHANNEL_ID % CHID_W'(SLOT_SCALE);
    req_slot  = SLOT_W'(slot_full);
    req_ch    = CH_W'(ch_full);
    slot_in   = slot_valid(slot_full);
    max_ch    = 7'(CH22_COUNT);
    if (slot_in) begin
      if (SLOT_TYPE[req_slot-1] == SLOT_TYPE_6) begin
        max_ch = 7'(CH6_COUNT);
      end else if (method[req_slot-1] == four_wire_method) begin
        max_ch = 7'(CH4W_COUNT);
      end
    end
    // full-width compares, so large slot or channel numbers cannot alias
    req_ok = slot_in && (ch_full >= CHID_W'(1))
             && (ch_full <= CHID_W'(max_ch));
  end

  assign cfg_write     = METHOD_WRITE || SHIELD_WRITE;
  assign COMMAND_READY = !query_pend;

  always_comb begin
    for (int i = 0; i < SLOTS; i++) begin
      next_method[i] = method[i];
      next_shield[i] = shield[i];
    end
    // settings move only while idle, when the relays are opened too
    if (COMMAND_READY && state == S_IDLE && METHOD_WRITE
        && slot_valid(CHID_W'(SET_SLOT))
        && method_ok(SLOT_TYPE[SET_SLOT-1], SET_METHOD)) begin
      next_method[SET_SLOT-1] = rcseq_method_type'(SET_METHOD);
      next_shield[SET_SLOT-1] =
        default_shield(rcseq_method_type'(SET_METHOD));
    end else if (COMMAND_READY && state == S_IDLE && SHIELD_WRITE
                 && slot_valid(CHID_W'(SET_SLOT))
                 && shield_ok(SLOT_TYPE[SET_SLOT-1], SET_SHIELD)) begin
      next_shield[SET_SLOT-1] = rcseq_shield_type'(SET_SHIELD);
    end
  end

  always_comb begin
    next_state      = state;
    next_cur_slot   = cur_slot;
    next_cur_ch     = cur_ch;
    next_tgt_slot   = tgt_slot;
    next_tgt_ch     = tgt_ch;
    next_closed     = closed;
    next_bus        = bus;
    next_wait_cnt   = wait_cnt;
    next_width      = width;
    next_pulse      = pulse;
    next_pulse_cnt  = pulse_cnt;
    next_query_pend = query_pend;
    next_reply_v    = 1'b0;
    next_reject     = 1'b0;
    if (pulse) begin
      if (pulse_cnt <= 1) begin
        next_pulse = 1'b0;
      end else begin
        next_pulse_cnt = pulse_cnt - 1;
      end
    end
    if (COMMAND_READY && COMPLETE_QUERY) begin
      next_query_pend = 1'b1;
    end
    if (query_pend && state == S_IDLE) begin
      next_query_pend = 1'b0;
      next_reply_v    = 1'b1;
    end
    case (state)
      S_IDLE: begin
        if (COMMAND_READY && (cfg_write || OPEN_ALL_REQUEST)) begin
          next_closed = 1'b0;
          next_bus    = '0;
        end else if (COMMAND_READY && CLOSE_REQUEST) begin
          if (req_ok) begin
            next_tgt_slot = req_slot;
            next_tgt_ch   = req_ch;
            next_pulse    = 1'b0;
            next_wait_cnt = CNT_W'(SETTLE_CYC) + CHANNEL_DELAY;
            next_width    = PULSE_WIDTH;
            next_closed   = 1'b0;
            if (req_slot != cur_slot) begin
              next_bus = '0;
            end
            next_state = S_BREAK;
          end else begin
            next_reject = 1'b1;
          end
        end
      end
      S_BREAK: begin
        next_bus[tgt_slot-1] = 1'b1;
        next_cur_slot = tgt_slot;
        next_cur_ch   = tgt_ch;
        next_closed   = 1'b1;
        next_state    = S_MAKE;
      end
      S_MAKE: begin
        next_state = S_WAIT;
      end
      S_WAIT: begin
        // relay time lies inside the delay, not added
        if (wait_cnt <= CNT_W'(RELAY_CYC)) begin
          next_state = S_DONE;
        end else begin
          next_wait_cnt = wait_cnt - 1;
        end
      end
      S_DONE: begin
        next_pulse     = (width != 0);
        next_pulse_cnt = width;
        next_state     = S_IDLE;
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      for (int i = 0; i < SLOTS; i++) begin
        method[i] <= two_wire_method;
        shield[i] <= SHLD_T1_LOW;
      end
      state      <= S_IDLE;
      cur_slot   <= '0;
      cur_ch     <= '0;
      tgt_slot   <= '0;
      tgt_ch     <= '0;
      closed     <= 1'b0;
      bus        <= '0;
      wait_cnt   <= '0;
      width      <= '0;
      pulse      <= 1'b0;
      pulse_cnt  <= '0;
      query_pend <= 1'b0;
      reply_v    <= 1'b0;
      reject     <= 1'b0;
    end else begin
      for (int i = 0; i < SLOTS; i++) begin
        method[i] <= next_method[i];
        shield[i] <= next_shield[i];
      end
      state      <= next_state;
      cur_slot   <= next_cur_slot;
      cur_ch     <= next_cur_ch;
      tgt_slot   <= next_tgt_slot;
      tgt_ch     <= next_tgt_ch;
      closed     <= next_closed;
      bus        <= next_bus;
      wait_cnt   <= next_wait_cnt;
      width      <= next_width;
      pulse      <= next_pulse;
      pulse_cnt  <= next_pulse_cnt;
      query_pend <= next_query_pend;
      reply_v    <= next_reply_v;
      reject     <= next_reject;
    end
  end

  always_comb begin
    for (int i = 0; i < SLOTS; i++) begin
      SHIELD_SELECT[3*i +: 3] = shield[i];
      METHOD_SELECT[2*i +: 2] = method[i];
    end
  end

  assign QUERY_REPLY_VALID     = reply_v;
  assign QUERY_REPLY           = 8'h01;
  assign CLOSE_REJECT          = reject;
  assign BUS_RELAY             = bus;
  assign RELAY_SLOT            = cur_slot;
  assign CHANNEL_CLOSED        = closed;
  assign CHANNEL_RELAY         = closed ? cur_ch : '0;
  // four-wire sense partner
  assign SENSE_RELAY           = (closed && cur_slot != 0
                                  && method[cur_slot-1] == four_wire_method)
                                 ? cur_ch + CH_W'(SENSE_OFFSET) : '0;
  assign SWITCH_BUSY           = (state != S_IDLE);
  assign external_control_port = pulse;

endmodule // rcseq_top
`default_nettype wire

// >>> dv/rcseq_host.sv
// rcseq_host: host command source for the relay sequencer
// assumes rcseq_top on the same clock; one strobe per command
`timescale 1ns/10ps
`default_nettype none
module rcseq_host (
  input  wire logic        CLOCK,
  input  wire logic        COMMAND_READY,
  output logic             METHOD_WRITE,
  output logic             SHIELD_WRITE,
  output logic [3:0]       SET_SLOT,
  output logic [1:0]       SET_METHOD,
  output logic [2:0]       SET_SHIELD,
  output logic             CLOSE_REQUEST,
  output logic [10:0]      CLOSE_CHANNEL_ID,
  output logic             OPEN_ALL_REQUEST,
  output logic             COMPLETE_QUERY
);
  int lost = 0;
  initial begin
    {COMPLETE_QUERY, CLOSE_REQUEST, OPEN_ALL_REQUEST} = 3'h0;
    {SHIELD_WRITE, METHOD_WRITE, SET_SLOT, SET_METHOD} = 8'h00;
    {SET_SHIELD, CLOSE_CHANNEL_ID} = 14'h0000;
  end
  // dual shield chosen once by the slot test, to be refused on six-channel slot 2
  // k: query, close, open-all, shield, method; v: slot, value
  task automatic send(input logic [4:0] k, input logic [10:0] v);
    int n;
    n = 0;
    @(posedge CLOCK);
    while (COMMAND_READY !== 1'b1 && n < 2000) begin
      @(posedge CLOCK);
      n++;
    end
    if (n == 2000) lost++;
    {COMPLETE_QUERY, CLOSE_REQUEST, OPEN_ALL_REQUEST} <= k[4:2];
    {SHIELD_WRITE, METHOD_WRITE} <= k[1:0];
    SET_SLOT <= v[3:0];
    SET_METHOD <= v[5:4];
    SET_SHIELD <= v[6:4];
    CLOSE_CHANNEL_ID <= v;
    @(posedge CLOCK);
    {COMPLETE_QUERY, CLOSE_REQUEST, OPEN_ALL_REQUEST} <= 3'h0;
    {SHIELD_WRITE, METHOD_WRITE} <= 2'h0;
    #1;
  endtask
  task automatic close(input int slot, input int ch);
    send(5'h08, 11'(slot * 100 + ch));
  endtask
endmodule // rcseq_host
`default_nettype wire

// >>> dv/rcseq_assertions.sv
// rcseq_checker: port checks of the relay sequencer
// assumes bind to rcseq_top, one clock domain
`timescale 1ns/10ps
`default_nettype none
module rcseq_checker
  import rcseq_pkg::*;
(
  input wire logic              CLOCK,
  input wire logic              RESET,
  input wire logic              METHOD_WRITE,
  input wire logic              SHIELD_WRITE,
  input wire logic              OPEN_ALL_REQUEST,
  input wire logic              CLOSE_REQUEST,
  input wire logic [CHID_W-1:0] CLOSE_CHANNEL_ID,
  input wire logic              COMPLETE_QUERY,
  input wire logic [CNT_W-1:0]  PULSE_WIDTH,
  input wire logic              COMMAND_READY,
  input wire logic              QUERY_REPLY_VALID,
  input wire logic [7:0]        QUERY_REPLY,
  input wire logic              CLOSE_REJECT,
  input wire logic [SLOTS-1:0]  BUS_RELAY,
  input wire logic [CH_W-1:0]   CHANNEL_RELAY,
  input wire logic [CH_W-1:0]   SENSE_RELAY,
  input wire logic              CHANNEL_CLOSED,
  input wire logic              SWITCH_BUSY,
  input wire logic              external_control_port
);
  logic              acc;
  logic [SLOT_W-1:0] slot;
  logic [SLOTS-1:0]  mask, req_mask;
  assign slot = SLOT_W'(CLOSE_CHANNEL_ID / SLOT_SCALE);
  assign req_mask = SLOTS'(1) << (slot - SLOT_W'(1));
  assign acc = CLOSE_REQUEST && COMMAND_READY && !SWITCH_BUSY
    && !METHOD_WRITE && !SHIELD_WRITE && !OPEN_ALL_REQUEST;
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) mask <= '0;
    else if (acc) mask <= req_mask;
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  sequence s_take; acc ##1 !CLOSE_REJECT; endsequence
  sequence s_wait;
    (SWITCH_BUSY && !external_control_port) [*8]
      ##[1:1000] $rose(external_control_port);
  endsequence
  property p_break; acc |=> CLOSE_REJECT || !CHANNEL_CLOSED; endproperty
  property p_make;
    s_take |=> CHANNEL_CLOSED && BUS_RELAY == mask;
  endproperty
  property p_keep;
    acc && CHANNEL_CLOSED && BUS_RELAY == req_mask
      |=> $stable(BUS_RELAY) [*2];
  endproperty
  property p_one; $onehot0(BUS_RELAY); endproperty
  property p_open;
    (OPEN_ALL_REQUEST || METHOD_WRITE || SHIELD_WRITE) && COMMAND_READY
      && !SWITCH_BUSY
      |=> !CHANNEL_CLOSED && BUS_RELAY == '0;
  endproperty
  property p_reject;
    CLOSE_REJECT |-> $stable(BUS_RELAY) && $stable(CHANNEL_RELAY);
  endproperty
  property p_reply;
    QUERY_REPLY_VALID |-> QUERY_REPLY == 8'h01 && !SWITCH_BUSY;
  endproperty
  property p_hold;
    COMPLETE_QUERY && COMMAND_READY && SWITCH_BUSY |=> !COMMAND_READY;
  endproperty
  property p_cut; s_take |-> !external_control_port; endproperty
  property p_wait;
    $rose(CHANNEL_CLOSED) && PULSE_WIDTH != '0 |-> s_wait;
  endproperty
  property p_sense;
    CHANNEL_CLOSED && SENSE_RELAY != '0
      |-> SENSE_RELAY == CHANNEL_RELAY + CH_W'(SENSE_OFFSET)
          && SENSE_RELAY > CH_W'(CH4W_COUNT)
          && SENSE_RELAY <= CH_W'(CH22_COUNT);
  endproperty
  a_break:  assert property (p_break) else $error("close did not break");
  a_make:   assert property (p_make) else $error("close did not make");
  a_keep:   assert property (p_keep) else $error("bus relay moved");
  a_one:    assert property (p_one) else $error("two buses closed");
  a_open:   assert property (p_open) else $error("relays not opened");
  a_reject: assert property (p_reject) else $error("reject moved relay");
  a_reply:  assert property (p_reply) else $error("early reply");
  a_hold:   assert property (p_hold) else $error("query not held");
  a_cut:    assert property (p_cut) else $error("pulse not cut");
  a_wait:   assert property (p_wait) else $error("bad settle wait");
  a_sense:  assert property (p_sense) else $error("bad sense pair");
endmodule // rcseq_checker
bind rcseq_top rcseq_checker u_chk (.CLOCK, .RESET, .METHOD_WRITE,
  .SHIELD_WRITE, .OPEN_ALL_REQUEST, .CLOSE_REQUEST, .CLOSE_CHANNEL_ID,
  .COMPLETE_QUERY, .PULSE_WIDTH, .COMMAND_READY, .QUERY_REPLY_VALID,
  .QUERY_REPLY, .CLOSE_REJECT, .BUS_RELAY, .CHANNEL_RELAY, .SENSE_RELAY,
  .CHANNEL_CLOSED, .SWITCH_BUSY, .external_control_port);
`default_nettype wire

// >>> dv/rcseq_top_test.sv
// rcseq_top_test: scenario bench for the relay sequencer
// assumes rcseq_host as command source, checker bound
`timescale 1ns/10ps
`default_nettype none
module rcseq_top_test;
  import rcseq_pkg::*;
  logic CLOCK = 1'b0, RESET = 1'b1, mw, sw, cr, oa, cq, rdy, qv, rj, cc, bz, ep;
  logic [3:0] ss, rs;
  logic [1:0] sm;
  logic [2:0] sh;
  logic [10:0] id;
  logic [7:0] qr;
  logic [11:0] st = 12'h002, br;
  logic [4:0] ch, se;
  logic [35:0] shs;
  logic [23:0] ms;
  int bad_count = 0, samples_checked = 0;
  always #20 CLOCK = ~CLOCK;
  rcseq_host h (.CLOCK(CLOCK), .COMMAND_READY(rdy), .METHOD_WRITE(mw),
    .SHIELD_WRITE(sw), .SET_SLOT(ss), .SET_METHOD(sm), .SET_SHIELD(sh),
    .CLOSE_REQUEST(cr), .CLOSE_CHANNEL_ID(id), .OPEN_ALL_REQUEST(oa),
    .COMPLETE_QUERY(cq));
  rcseq_top DUT (.CLOCK(CLOCK), .RESET(RESET), .SLOT_TYPE(st),
    .METHOD_WRITE(mw), .SHIELD_WRITE(sw), .SET_SLOT(ss), .SET_METHOD(sm),
    .SET_SHIELD(sh), .CLOSE_REQUEST(cr), .CLOSE_CHANNEL_ID(id),
    .OPEN_ALL_REQUEST(oa), .COMPLETE_QUERY(cq), .CHANNEL_DELAY(32'h82),
    .PULSE_WIDTH(32'h28), .COMMAND_READY(rdy), .QUERY_REPLY_VALID(qv),
    .QUERY_REPLY(qr), .CLOSE_REJECT(rj), .BUS_RELAY(br), .RELAY_SLOT(rs),
    .CHANNEL_RELAY(ch), .SENSE_RELAY(se), .CHANNEL_CLOSED(cc),
    .SHIELD_SELECT(shs), .METHOD_SELECT(ms), .SWITCH_BUSY(bz),
    .external_control_port(ep));
  task automatic wrap_up();
    chk("host stall", 36'(h.lost), 36'h0);
    $display("checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string w, input logic [35:0] g, e);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: %s got %0h want %0h", $time, w, g, e);
    end
  endtask
  task automatic wait_for(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 2000) begin
      @(posedge CLOCK);
      #1;
      n++;
    end
    if (n == 2000) begin
      chk("timeout", 36'h1, 36'h0);
      wrap_up();
    end
  endtask
  task automatic t_four_wire();
    chk("shields", shs, 36'h492492492);
    h.send(5'h01, 11'h011);
    chk("shield1", 36'(shs[2:0]), 36'h1);
    chk("method1", 36'(ms[1:0]), 36'h1);
    h.close(1, 7);
    h.send(5'h10, 11'h000);
    wait_for(qv, 1'b1);
    chk("reply", 36'(qr), 36'h1);
    chk("chan", 36'(ch), 36'h7);
    chk("sense", 36'(se), 36'h12);
    chk("bus", 36'(br), 36'h1);
    wait_for(ep, 1'b1);
    h.close(1, 8);
    chk("pulse", 36'(ep), 36'h0);
    wait_for(bz, 1'b0);
    chk("chan", 36'(ch), 36'h8);
    $display("four-wire test done");
  endtask
  task automatic t_slot2();
    int n;
    h.send(5'h01, 11'h022);
    chk("shield2", 36'(shs[5:3]), 36'h4);
    chk("open", 36'(cc), 36'h0);
    h.send(5'h02, 11'h052);
    chk("illegal", 36'(shs[5:3]), 36'h4);
    h.send(5'h02, 11'h012);
    chk("gnd", 36'(shs[5:3]), 36'h1);
    h.close(2, 3);
    wait_for(bz, 1'b0);
    n = 0;
    while (ep === 1'b1 && n < 100) begin
      @(posedge CLOCK);
      #1;
      n++;
    end
    chk("width", 36'(n), 36'h28);
    chk("bus", 36'(br), 36'h2);
    chk("slot", 36'(rs), 36'h2);
    chk("kept", 36'(shs[5:3]), 36'h1);
    h.close(2, 7);
    chk("reject", 36'(rj), 36'h1);
    chk("chan", 36'(ch), 36'h3);
    $display("slot test done");
  endtask
  task automatic t_open();
    h.send(5'h02, 11'h031);
    chk("shopen", 36'(cc), 36'h0);
    chk("shield1", 36'(shs[2:0]), 36'h3);
    h.close(1, 6);
    wait_for(bz, 1'b0);
    h.send(5'h04, 11'h000);
    chk("closed", 36'(cc), 36'h0);
    chk("bus", 36'(br), 36'h0);
    $display("open test done");
  endtask
  initial begin
    repeat (4) @(posedge CLOCK);
    RESET <= 1'b0;
    t_four_wire();
    t_slot2();
    t_open();
    wrap_up();
  end
endmodule // rcseq_top_test
`default_nettype wire
